// *** src/uarx_regs.svh ***
// timing and frame constants for the asynchronous receive front end
// assumes a single system clock; no software-visible registers
`ifndef UARX_REGS_SVH
`define UARX_REGS_SVH
`define UARX_OSR_NORMAL     5'h10
`define UARX_OSR_DOUBLE     5'h08
`define UARX_VOTE_A_NORMAL  5'h08
`define UARX_VOTE_A_DOUBLE  5'h04
`define UARX_DBITS_MIN      4'h5
`define UARX_DBITS_MAX      4'ha
`define UARX_DIV_W          12
`endif

// *** src/uarx_pkg.sv ***
// types shared by the asynchronous receive front end
// assumes uarx_regs.svh supplies the numeric constants
package uarx_pkg;
    typedef enum logic [1:0] {
        UARX_IDLE,
        UARX_START,
        UARX_BITS
    } uarx_state_t;

    typedef struct packed {
        logic [9:0] data;
        logic       stop_bit_error_flag;
    } uarx_frame_t;
endpackage

// *** src/uarx_rx.sv ***
// asynchronous receive front end: start detection, bit timing, majority voting
// assumes a downstream receive buffer that accepts a frame whenever o_frame_valid pulses
//
// Functional notes
// - oversample the line at 16x normally, 8x with double speed select
// - idle high-to-low transition starts detection; first low sample is sample one
// - qualify start with samples 8,9,10 (normal) or 4,5,6 (double)
// - two or more high qualification samples reject start as noise
// - valid start aligns bit timing; alignment repeats every frame
// - per-bit state sequence of 16 or 8 states numbers each sample
// - each data and parity bit is the majority of three centre samples
// - recover bits through first stop bit; further stop bits ignored
// - first stop bit voted; zero sets the stop bit error flag
// - next falling edge accepted right after the last stop voting sample
// - frames carry five to ten data-plus-parity bits
// - stop bit error flag travels with its frame to the buffer
// - clearing receiver enable stops reception, drops frame, flushes buffer
`timescale 1ns/1ps
`include "uarx_regs.svh"

module uarx_rx (
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_rxd,
    input  wire logic                     i_receiver_enable,
    input  wire logic                     i_double_speed_select,
    input  wire logic [`UARX_DIV_W-1:0]   i_baud_divisor,
    input  wire logic [3:0]               i_dbits,
    output logic                          o_frame_valid,
    output uarx_pkg::uarx_frame_t         o_frame,
    output logic                          o_flush,
    output logic                          o_busy
);
    logic                    sync1_r;
    logic                    sync2_r;
    logic                    prev_r;
    logic [`UARX_DIV_W-1:0]  div_r;
    logic                    tick;
    logic [4:0]              samp_r;
    logic [3:0]              bit_r;
    logic [2:0]              votes_r;
    logic [9:0]              shift_r;
    uarx_pkg::uarx_state_t   state_r;
    logic [4:0]              osr;
    logic [4:0]              va;
    logic [3:0]              nbits;
    logic                    majority;
    logic                    in_vote;
    logic                    vote_end;
    logic [4:0]              qual_cnt_r;

    // first stage is read only by the second
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= i_rxd;
            sync2_r <= sync1_r;
        end
    end

    // oversampling tick; divisor of n gives one tick every n+1 clocks
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= '0;
        end else if (!i_receiver_enable || div_r == '0) begin
            div_r <= i_baud_divisor;
        end else begin
            div_r <= div_r - 1'b1;
        end
    end
    assign tick = i_receiver_enable && div_r == '0;

    assign osr = i_double_speed_select ? `UARX_OSR_DOUBLE : `UARX_OSR_NORMAL;
    assign va  = i_double_speed_select ? `UARX_VOTE_A_DOUBLE : `UARX_VOTE_A_NORMAL;
    // out-of-range lengths clamp so a frame always ends
    assign nbits = (i_dbits < `UARX_DBITS_MIN) ? `UARX_DBITS_MIN :
                   (i_dbits > `UARX_DBITS_MAX) ? `UARX_DBITS_MAX : i_dbits;
    assign in_vote  = samp_r >= va && samp_r <= va + 5'h02;
    assign vote_end = samp_r == va + 5'h02;
    // votes_r holds the two earlier centre samples; third is the current one
    assign majority = (votes_r[1] & votes_r[0]) | (votes_r[1] & sync2_r)
                    | (votes_r[0] & sync2_r);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_r <= 1'b1;
        end else if (tick) begin
            prev_r <= sync2_r;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            votes_r <= '0;
        end else if (tick && in_vote) begin
            votes_r <= {votes_r[1:0], sync2_r};
        end
    end

    // main sequencer
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= uarx_pkg::UARX_IDLE;
            samp_r  <= '0;
            bit_r   <= '0;
            shift_r <= '0;
        end else if (!i_receiver_enable) begin
            state_r <= uarx_pkg::UARX_IDLE;
            samp_r  <= '0;
            bit_r   <= '0;
        end else if (tick) begin
            unique case (state_r)
                uarx_pkg::UARX_IDLE: begin
                    if (prev_r && !sync2_r) begin
                        state_r <= uarx_pkg::UARX_START;
                        samp_r  <= 5'h02;
                    end
                end
                uarx_pkg::UARX_START: begin
                    if (vote_end) begin
                        if (majority) begin
                            state_r <= uarx_pkg::UARX_IDLE;
                        end else begin
                            state_r <= uarx_pkg::UARX_BITS;
                            bit_r   <= '0;
                        end
                    end
                    // count to the end of the start bit, then restart at 1
                    samp_r <= (samp_r == osr) ? 5'h01 : samp_r + 5'h01;
                end
                uarx_pkg::UARX_BITS: begin
                    // wrap at the end of the start bit and of each data bit: state returns to 1 after osr
                    if (samp_r == osr) begin
                        samp_r <= 5'h01;
                    end else begin
                        samp_r <= samp_r + 5'h01;
                    end
                    if (vote_end) begin
                        if (bit_r == nbits) begin
                            state_r <= uarx_pkg::UARX_IDLE;
                        end else begin
                            shift_r <= {majority, shift_r[9:1]};
                            bit_r   <= bit_r + 4'h1;
                        end
                    end
                end
                default: state_r <= uarx_pkg::UARX_IDLE;
            endcase
        end
    end

    // assertion helper: sample number of a start under qualification, counted apart
    // from samp_r so that a wrong vote point in the sequencer cannot hide itself
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qual_cnt_r <= 5'h02;
        end else if (state_r != uarx_pkg::UARX_START) begin
            qual_cnt_r <= 5'h02;
        end else if (tick) begin
            qual_cnt_r <= qual_cnt_r + 5'h01;
        end
    end

    // frame handed to the buffer at the stop vote, data right aligned
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_frame_valid <= 1'b0;
            o_frame       <= '0;
        end else begin
            o_frame_valid <= 1'b0;
            if (i_receiver_enable && tick && state_r == uarx_pkg::UARX_BITS
                    && vote_end && bit_r == nbits) begin
                o_frame_valid                <= 1'b1;
                o_frame.data                 <= shift_r >> (4'ha - nbits);
                o_frame.stop_bit_error_flag  <= ~majority;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flush <= 1'b1;
            o_busy  <= 1'b0;
        end else begin
            o_flush <= ~i_receiver_enable;
            o_busy  <= i_receiver_enable && state_r != uarx_pkg::UARX_IDLE;
        end
    end

    chk_noise_reject: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_receiver_enable && tick && state_r == uarx_pkg::UARX_START && vote_end && majority)
        |=> state_r == uarx_pkg::UARX_IDLE)
        else $error("noise start not rejected");
    chk_stop_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_receiver_enable && tick && state_r == uarx_pkg::UARX_BITS && vote_end
         && bit_r == nbits) |=> o_frame_valid && o_frame.stop_bit_error_flag == $past(~majority))
        else $error("stop flag wrong");
    chk_disable_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_receiver_enable |=> state_r == uarx_pkg::UARX_IDLE && o_flush)
        else $error("disable did not abort");
    chk_samp_range: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_r != uarx_pkg::UARX_IDLE |-> samp_r >= 5'h01 && samp_r <= osr)
        else $error("sample state out of range");
    chk_start_begin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_receiver_enable && tick && state_r == uarx_pkg::UARX_IDLE && prev_r && !sync2_r)
        |=> state_r == uarx_pkg::UARX_START && samp_r == 5'h02)
        else $error("start not detected");
    chk_valid_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_frame_valid |=> !o_frame_valid)
        else $error("frame valid longer than one cycle");
    chk_vote_window: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_receiver_enable && tick && state_r == uarx_pkg::UARX_START
         && qual_cnt_r == va + 5'h02) |=> state_r != uarx_pkg::UARX_START)
        else $error("start vote at wrong sample");
    chk_bits_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        bit_r <= `UARX_DBITS_MAX)
        else $error("bit count beyond frame");

    cov_frame_ok:  cover property (@(posedge i_mclk) o_frame_valid && !o_frame.stop_bit_error_flag);
    cov_frame_err: cover property (@(posedge i_mclk) o_frame_valid && o_frame.stop_bit_error_flag);
    cov_noise:     cover property (@(posedge i_mclk) tick && state_r == uarx_pkg::UARX_START
                                   && vote_end && majority);
    cov_double:    cover property (@(posedge i_mclk) o_frame_valid && i_double_speed_select);
endmodule

// *** dv/uarx_tx_model.sv ***
// remote serial transmitter model driving the receive line
// assumes the receiver shares i_mclk; the line idles high between frames
`timescale 1ns/1ps
module uarx_tx_model (
    input  wire logic i_mclk,
    output logic      o_line
);
    initial o_line = 1'b1;
    task automatic hold(input logic v, input int ck);
        repeat (ck) begin
            @(posedge i_mclk);
            #1 o_line = v;
        end
    endtask
    // exact bit period, so the rate error is zero and well inside tolerance
    task automatic send(input logic [9:0] d, input int n, input int ck, input logic stop,
                        input int stop_ck, input int glitch);
        hold(1'b0, ck);
        for (int b = 0; b < n; b++) begin
            if (b == glitch) begin
                hold(d[b], ck / 2);
                hold(~d[b], 1);
                hold(d[b], ck - ck / 2 - 1);
            end else begin
                hold(d[b], ck);
            end
        end
        hold(stop, stop_ck);
    endtask
endmodule

// *** dv/uarx_rx_tb.sv ***
// self-checking bench for the receive front end, line driven by a transmitter model
// assumes a 200 MHz clock; frames arrive at an exact bit rate
`timescale 1ns/1ps
module uarx_rx_tb;
    logic                  i_mclk = 1'b0;
    logic                  i_rst_n = 1'b0;
    logic                  en = 1'b1;
    logic                  dbl = 1'b0;
    logic [11:0]           div = 12'h000;
    logic [3:0]            nb = 4'h8;
    logic                  line, vld, flush, busy;
    uarx_pkg::uarx_frame_t frm;
    uarx_pkg::uarx_frame_t got[$];
    int                    errors = 0;
    int                    check_count = 0;
    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (vld === 1'b1) got.push_back(frm);
    uarx_tx_model tx (.i_mclk(i_mclk), .o_line(line));
    uarx_rx dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rxd(line), .i_receiver_enable(en),
        .i_double_speed_select(dbl), .i_baud_divisor(div), .i_dbits(nb),
        .o_frame_valid(vld), .o_frame(frm), .o_flush(flush), .o_busy(busy));
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic setup(input logic d2x, input logic [11:0] dv, output int ck);
        @(posedge i_mclk);
        #1 dbl = d2x;
        div = dv;
        ck = (d2x ? 8 : 16) * (int'(dv) + 1);
        tx.hold(1'b1, ck);
        got = {};
    endtask
    // a missing frame pops as all ones, which no expectation here equals
    task automatic pop_frame(input int cnt, input logic [9:0] d, input logic stop);
        uarx_pkg::uarx_frame_t f;
        f = '1;
        if (cnt == 1) tx.hold(1'b1, 8);
        if (cnt == 1) check("count", 11'(got.size()), 11'h001);
        if (got.size() > 0) f = got.pop_front();
        check("frame", f, {d & 10'((1 << int'(nb)) - 1), ~stop});
    endtask
    task automatic sc_sizes;
        int ck;
        for (int n = 5; n <= 10; n++) begin
            nb = 4'(n);
            setup(n[0], 12'h000, ck);
            tx.send(10'h2b5 ^ 10'(n), n, ck, 1'b1, ck, n - 2);
            pop_frame(1, 10'h2b5 ^ 10'(n), 1'b1);
        end
        nb = 4'h8;
        for (int m = 0; m < 2; m++) begin
            setup(m[0], 12'h001, ck);
            tx.send(10'h0c3, 8, ck, 1'b0, ck, -1);
            pop_frame(1, 10'h0c3, 1'b0);
        end
    endtask
    task automatic sc_start_qual;
        int ck;
        for (int m = 0; m < 2; m++) begin
            setup(m[0], 12'h000, ck);
            tx.hold(1'b0, ck / 2);
            tx.hold(1'b1, 2 * ck);
            check("noise count", 11'(got.size()), 11'h000);
            check("noise busy", 11'(busy), 11'h000);
            tx.hold(1'b0, ck / 2 + 1);
            tx.hold(1'b1, 10 * ck);
            pop_frame(1, 10'h3ff, 1'b1);
        end
    endtask
    task automatic sc_back_to_back;
        int ck;
        for (int m = 0; m < 2; m++) begin
            setup(m[0], 12'h000, ck);
            tx.send(10'h0a5, 8, ck, 1'b1, m ? 6 : 10, -1);
            tx.send(10'h05a, 8, ck, 1'b1, ck, -1);
            tx.hold(1'b1, 8);
            check("pair count", 11'(got.size()), 11'h002);
            pop_frame(2, 10'h0a5, 1'b1);
            pop_frame(2, 10'h05a, 1'b1);
        end
    endtask
    task automatic sc_disable;
        int ck;
        setup(1'b0, 12'h000, ck);
        fork
            tx.send(10'h0ff, 8, ck, 1'b1, ck, -1);
            begin
                repeat (3 * ck) @(posedge i_mclk);
                #1 check("busy", 11'(busy), 11'h001);
                en = 1'b0;
                repeat (3) @(posedge i_mclk);
                #1 check("flush", 11'(flush), 11'h001);
                check("abort busy", 11'(busy), 11'h000);
            end
        join
        tx.hold(1'b1, 8);
        check("aborted count", 11'(got.size()), 11'h000);
        en = 1'b1;
        tx.hold(1'b1, 4);
        check("flush off", 11'(flush), 11'h000);
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        #1 check("reset flush", 11'(flush), 11'h001);
        repeat (4) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        sc_sizes();
        sc_start_qual();
        sc_back_to_back();
        sc_disable();
        final_report();
    end
    initial begin
        #400000;
        errors++;
        final_report();
    end
endmodule
